//--- uwtb_top.v
// Chosen here: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
`include "uwtb_regs.vh"
// Overview of operation
// - Full-duplex serial port, 8-bit mode and 9-bit mode only.
// - Received byte is buffered while the next one shifts in.
// - Writing the data location loads the transmitter and starts sending.
// - Reading the data location returns the receive buffer only.
// - Start of the stop bit sets tx_done_flag, interrupting when enabled.
// - Received byte sets rx_done_flag, interrupting when enabled.
// - Both flags stay set until software clears them.
// - Bit rate comes from an 8-bit auto-reload timer.
// - Transmit uses the timer low counter; receive a private copy.
// - Both timer overflow streams are halved to give bit rates.
// - Receive copy counts with the timer and shares the reload byte.
// - A start condition forces a reload of the receive copy.
// - Timer clock: system, /4, /12, /48, oscillator /8, or pin.
// - 8-bit frame: start, eight data LSB first, stop into ninth flag.
// - 9-bit frame: start, eight data, ninth bit, stop ignored.
// - tx_done_flag rises at the start of the stop bit.
module uwtb_top (
  input wire MCLK, // System clock
  input wire RST, // Synchronous reset, active high
  input wire CE, // Clock enable, freezes all state when low
  input wire WB_CYC_I, // Bus cycle
  input wire WB_STB_I, // Bus strobe
  input wire WB_WE_I, // Write enable
  input wire [4:0] WB_ADR_I, // Byte address
  input wire [3:0] WB_SEL_I, // Byte lanes
  input wire [31:0] WB_DAT_I, // Write data
  output reg [31:0] WB_DAT_O, // Read data
  output reg WB_ACK_O, // Acknowledge
  input wire RXD, // Serial input pin
  input wire T1_PIN, // timer1_external_input pin
  input wire EXT_OSC, // External oscillator clock
  output wire TXD, // Serial output pin
  output reg IRQ // Level interrupt
);
  localparam RX_IDLE = 1'b0;
  localparam RX_RECV = 1'b1;

  function hit;
    input [4:0] adr;
    input [4:0] ofs;
    begin
      hit = (adr[4:2] == ofs[4:2]);
    end
  endfunction

  // Control and configuration
  reg mode9_q;
  reg rxen_q;
  reg mce_q;
  reg txb9_q;
  reg [7:0] reload_q;
  reg [2:0] src_q;
  reg run_q;
  reg [7:0] low_q;
  reg [1:0] ien_q;
  reg [1:0] sts_q;
  reg [1:0] sts_d;
  // Prescalers
  reg [1:0] c4_q;
  reg [3:0] c12_q;
  reg [1:0] c48_q;
  reg [2:0] c8_q;
  reg osc_d_q;
  reg pin_d_q;
  reg tick;
  // Baud generation
  reg [7:0] rxt_q;
  reg txh_q;
  reg rxh_q;
  // Receiver
  reg rx_st_q;
  reg [3:0] rbit_q;
  reg [7:0] rsh_q;
  reg r9_q;
  reg [7:0] rbuf_q;
  reg rb9_q;
  reg rx_d_q;
  reg [31:0] rdata;

  wire [2:0] pins_s;
  wire rx_s = pins_s[0];
  wire pin_s = pins_s[1];
  wire osc_s = pins_s[2];
  wire tx_busy;
  wire tx_done;
  wire rx_load;

  wire acc = WB_CYC_I & WB_STB_I;
  // Writes take effect on the edge that the master sees ack
  wire wr = acc & WB_WE_I & WB_ACK_O;
  wire wr_ctrl = wr & hit(WB_ADR_I, `UWTB_OFS_CTRL) & WB_SEL_I[0];
  wire wr_data = wr & hit(WB_ADR_I, `UWTB_OFS_DATA) & WB_SEL_I[0];
  wire wr_tmr0 = wr & hit(WB_ADR_I, `UWTB_OFS_TMR) & WB_SEL_I[0];
  wire wr_tmr1 = wr & hit(WB_ADR_I, `UWTB_OFS_TMR) & WB_SEL_I[1];
  wire wr_clr = wr & hit(WB_ADR_I, `UWTB_OFS_CLR) & WB_SEL_I[0];
  wire wr_ien = wr & hit(WB_ADR_I, `UWTB_OFS_IEN) & WB_SEL_I[0];
  wire wr_low = wr & hit(WB_ADR_I, `UWTB_OFS_LOW) & WB_SEL_I[0];

  uwtb_sync #(
    .W(3)
  ) u_sync (
    .clk(MCLK),
    .rst(RST),
    .ce(CE),
    .din({EXT_OSC, T1_PIN, RXD}),
    .dout(pins_s)
  );

  // ---------------- Register file ----------------
  always @(posedge MCLK) begin
    if (RST) begin
      mode9_q <= 1'b0;
      rxen_q <= 1'b0;
      mce_q <= 1'b0;
      txb9_q <= 1'b0;
      reload_q <= `UWTB_RST_BYTE;
      src_q <= `UWTB_SRC_SYS;
      run_q <= 1'b0;
      ien_q <= 2'h0;
    end else if (CE) begin
      if (wr_ctrl) begin
        mode9_q <= WB_DAT_I[`UWTB_CTRL_MODE9];
        rxen_q <= WB_DAT_I[`UWTB_CTRL_RXEN];
        mce_q <= WB_DAT_I[`UWTB_CTRL_MCE];
        txb9_q <= WB_DAT_I[`UWTB_CTRL_TXB9];
      end
      if (wr_tmr0) begin
        reload_q <= WB_DAT_I[7:0];
      end
      if (wr_tmr1) begin
        src_q <= WB_DAT_I[`UWTB_TMR_SEL_LO+2:`UWTB_TMR_SEL_LO];
        run_q <= WB_DAT_I[`UWTB_TMR_RUN];
      end
      if (wr_ien) begin
        ien_q <= WB_DAT_I[1:0];
      end
    end
  end

  // Sticky flags; a set in the same cycle as a clear wins
  always @* begin
    sts_d = sts_q & ~(wr_clr ? WB_DAT_I[1:0] : 2'h0);
    sts_d[`UWTB_IRQ_TXD] = sts_d[`UWTB_IRQ_TXD] | tx_done;
    sts_d[`UWTB_IRQ_RXD] = sts_d[`UWTB_IRQ_RXD] | rx_load;
  end

  always @(posedge MCLK) begin
    if (RST) begin
      sts_q <= 2'h0;
      IRQ <= 1'b0;
    end else if (CE) begin
      sts_q <= sts_d;
      IRQ <= |(sts_q & ien_q);
    end
  end

  // ---------------- Bus slave ----------------
  always @* begin
    rdata = `UWTB_RST_WORD;
    if (hit(WB_ADR_I, `UWTB_OFS_CTRL)) begin
      rdata[`UWTB_CTRL_MODE9] = mode9_q;
      rdata[`UWTB_CTRL_RXEN] = rxen_q;
      rdata[`UWTB_CTRL_MCE] = mce_q;
      rdata[`UWTB_CTRL_TXB9] = txb9_q;
      rdata[`UWTB_CTRL_RXB9] = rb9_q;
      rdata[`UWTB_CTRL_BUSY] = tx_busy;
    end else if (hit(WB_ADR_I, `UWTB_OFS_DATA)) begin
      rdata[7:0] = rbuf_q;
    end else if (hit(WB_ADR_I, `UWTB_OFS_TMR)) begin
      rdata[7:0] = reload_q;
      rdata[`UWTB_TMR_SEL_LO+2:`UWTB_TMR_SEL_LO] = src_q;
      rdata[`UWTB_TMR_RUN] = run_q;
    end else if (hit(WB_ADR_I, `UWTB_OFS_STS)) begin
      rdata[1:0] = sts_q;
    end else if (hit(WB_ADR_I, `UWTB_OFS_IEN)) begin
      rdata[1:0] = ien_q;
    end else if (hit(WB_ADR_I, `UWTB_OFS_LOW)) begin
      rdata[7:0] = low_q;
    end
  end

  // Unmapped addresses are acked and read as zero
  always @(posedge MCLK) begin
    if (RST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= `UWTB_RST_WORD;
    end else if (CE) begin
      WB_ACK_O <= acc & ~WB_ACK_O;
      if (acc & ~WB_ACK_O & ~WB_WE_I) begin
        WB_DAT_O <= rdata;
      end
    end
  end

  // ---------------- Timer clock sources ----------------
  always @(posedge MCLK) begin
    if (RST) begin
      c4_q <= 2'h0;
      c12_q <= 4'h0;
      c48_q <= 2'h0;
      c8_q <= 3'h0;
      osc_d_q <= 1'b1;
      pin_d_q <= 1'b1;
    end else if (CE) begin
      osc_d_q <= osc_s;
      pin_d_q <= pin_s;
      c4_q <= c4_q + 2'h1;
      if (c12_q == `UWTB_DIV12_TOP) begin
        c12_q <= 4'h0;
        c48_q <= c48_q + 2'h1;
      end else begin
        c12_q <= c12_q + 4'h1;
      end
      if (osc_s & ~osc_d_q) begin
        c8_q <= c8_q + 3'h1;
      end
    end
  end

  // The oscillator and pin are sampled, so each must run below half of MCLK
  always @* begin
    case (src_q)
      `UWTB_SRC_SYS: tick = 1'b1;
      `UWTB_SRC_DIV4: tick = (c4_q == `UWTB_DIV4_TOP);
      `UWTB_SRC_DIV12: tick = (c12_q == `UWTB_DIV12_TOP);
      `UWTB_SRC_DIV48: tick = (c12_q == `UWTB_DIV12_TOP) & (c48_q == `UWTB_DIV48_TOP);
      `UWTB_SRC_OSC8: tick = osc_s & ~osc_d_q & (c8_q == `UWTB_OSC8_TOP);
      `UWTB_SRC_PIN: tick = ~pin_s & pin_d_q;
      default: tick = 1'b0;
    endcase
  end

  wire tick_en = run_q & tick;

  // ---------------- Baud timers ----------------
  wire start_det = (rx_st_q == RX_IDLE) & rxen_q & rx_d_q & ~rx_s;
  wire tovf = tick_en & (low_q == `UWTB_CNT_TOP);
  wire rovf = tick_en & (rxt_q == `UWTB_CNT_TOP);
  wire tx_baud = tovf & txh_q;
  // First receive overflow after the forced reload lands mid start bit
  wire rx_baud = rovf & ~rxh_q;

  always @(posedge MCLK) begin
    if (RST) begin
      low_q <= `UWTB_RST_BYTE;
      txh_q <= 1'b0;
    end else if (CE) begin
      if (wr_low) begin
        low_q <= WB_DAT_I[7:0];
      end else if (tovf) begin
        low_q <= reload_q;
      end else if (tick_en) begin
        low_q <= low_q + 8'h01;
      end
      if (tovf) begin
        txh_q <= ~txh_q;
      end
    end
  end

  // Private copy, invisible to software
  always @(posedge MCLK) begin
    if (RST) begin
      rxt_q <= `UWTB_RST_BYTE;
      rxh_q <= 1'b0;
    end else if (CE) begin
      if (start_det) begin
        rxt_q <= reload_q;
        rxh_q <= 1'b0;
      end else if (rovf) begin
        rxt_q <= reload_q;
        rxh_q <= ~rxh_q;
      end else if (tick_en) begin
        rxt_q <= rxt_q + 8'h01;
      end
    end
  end

  // ---------------- Transmitter ----------------
  uwtb_tx u_tx (
    .clk(MCLK),
    .rst(RST),
    .ce(CE),
    .baud(tx_baud),
    .start(wr_data),
    .data(WB_DAT_I[7:0]),
    .ninth(txb9_q),
    .mode9(mode9_q),
    .txd_q(TXD),
    .done(tx_done),
    .busy_q(tx_busy)
  );

  // ---------------- Receiver ----------------
  wire stop_ph = (rbit_q == (mode9_q ? `UWTB_BITS_9 : `UWTB_BITS_8) - 4'h1);
  wire last_bit = mode9_q ? r9_q : rx_s;
  assign rx_load = (rx_st_q == RX_RECV) & rx_baud & stop_ph
    & ~sts_q[`UWTB_IRQ_RXD] & (~mce_q | last_bit);

  always @(posedge MCLK) begin
    if (RST) begin
      rx_d_q <= 1'b1;
      rx_st_q <= RX_IDLE;
      rbit_q <= 4'h0;
      rsh_q <= `UWTB_RST_BYTE;
      r9_q <= 1'b0;
    end else if (CE) begin
      rx_d_q <= rx_s;
      case (rx_st_q)
        RX_IDLE: begin
          if (start_det) begin
            rx_st_q <= RX_RECV;
            rbit_q <= 4'h0;
          end
        end
        RX_RECV: begin
          if (rx_baud) begin
            if (rbit_q == 4'h0) begin
              // A glitch that is high again mid start bit is dropped
              if (rx_s) begin
                rx_st_q <= RX_IDLE;
              end
              rbit_q <= 4'h1;
            end else if (stop_ph) begin
              rx_st_q <= RX_IDLE;
            end else if (rbit_q <= `UWTB_RX_LAST_DATA) begin
              rsh_q <= {rx_s, rsh_q[7:1]};
              rbit_q <= rbit_q + 4'h1;
            end else begin
              r9_q <= rx_s;
              rbit_q <= rbit_q + 4'h1;
            end
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // Holding register separate from the shifter lets a new byte arrive
  always @(posedge MCLK) begin
    if (RST) begin
      rbuf_q <= `UWTB_RST_BYTE;
      rb9_q <= 1'b0;
    end else if (CE) begin
      if (rx_load) begin
        rbuf_q <= rsh_q;
        rb9_q <= last_bit;
      end
    end
  end
endmodule // uwtb_top

//--- uwtb_regs.vh
`ifndef UWTB_REGS_VH
`define UWTB_REGS_VH
// Byte offsets on the register bus
`define UWTB_OFS_CTRL 5'h00
`define UWTB_OFS_DATA 5'h04
`define UWTB_OFS_TMR 5'h08
`define UWTB_OFS_STS 5'h0C
`define UWTB_OFS_CLR 5'h10
`define UWTB_OFS_IEN 5'h14
`define UWTB_OFS_LOW 5'h18
// serial_port_control fields
`define UWTB_CTRL_MODE9 0
`define UWTB_CTRL_RXEN 1
`define UWTB_CTRL_MCE 2
`define UWTB_CTRL_TXB9 3
`define UWTB_CTRL_RXB9 4
`define UWTB_CTRL_BUSY 5
// Timer register fields
`define UWTB_TMR_SEL_LO 8
`define UWTB_TMR_RUN 11
// Status, clear and enable layout
`define UWTB_IRQ_TXD 0
`define UWTB_IRQ_RXD 1
// Timer clock source codes
`define UWTB_SRC_SYS 3'h0
`define UWTB_SRC_DIV4 3'h1
`define UWTB_SRC_DIV12 3'h2
`define UWTB_SRC_DIV48 3'h3
`define UWTB_SRC_OSC8 3'h4
`define UWTB_SRC_PIN 3'h5
// Prescaler and baud timer terminal counts
`define UWTB_DIV4_TOP 2'h3
`define UWTB_DIV12_TOP 4'hB
`define UWTB_DIV48_TOP 2'h3
`define UWTB_OSC8_TOP 3'h7
`define UWTB_CNT_TOP 8'hFF
// Frame lengths in bit periods and receive bit indices
`define UWTB_BITS_8 4'hA
`define UWTB_BITS_9 4'hB
`define UWTB_RX_LAST_DATA 4'h8
`define UWTB_RX_NINTH 4'h9
// Reset values
`define UWTB_RST_BYTE 8'h00
`define UWTB_RST_WORD 32'h00000000
`endif

//--- uwtb_sync.v
`timescale 1ns/100ps
module uwtb_sync #(
  parameter W = 3
) (
  input wire clk, // System clock
  input wire rst, // Synchronous reset
  input wire ce, // Clock enable
  input wire [W-1:0] din, // Asynchronous pin levels
  output wire [W-1:0] dout // Synchronised levels
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg s1_q;
      reg s2_q;
      // Pins idle high, so reset to one to avoid a false edge
      always @(posedge clk) begin
        if (rst) begin
          s1_q <= 1'b1;
          s2_q <= 1'b1;
        end else if (ce) begin
          s1_q <= din[i];
          s2_q <= s1_q;
        end
      end
      assign dout[i] = s2_q;
    end
  endgenerate
endmodule // uwtb_sync

//--- uwtb_tx.v
`timescale 1ns/100ps
`include "uwtb_regs.vh"
module uwtb_tx (
  input wire clk, // System clock
  input wire rst, // Synchronous reset
  input wire ce, // Clock enable
  input wire baud, // One pulse per bit period
  input wire start, // Load and start a character
  input wire [7:0] data, // Byte to send
  input wire ninth, // Ninth bit in 9-bit mode
  input wire mode9, // 9-bit framing
  output reg txd_q, // Serial output
  output wire done, // Pulse at start of stop bit
  output reg busy_q // Character in progress
);
  reg [10:0] sh_q;
  reg [3:0] cnt_q;
  wire [3:0] nbits = mode9 ? `UWTB_BITS_9 : `UWTB_BITS_8;
  wire [10:0] frame = mode9 ? {1'b1, ninth, data, 1'b0} : {2'b11, data, 1'b0};
  // Flag goes up as the stop bit starts, not when it ends
  assign done = busy_q & baud & (cnt_q == nbits - 4'h1);
  always @(posedge clk) begin
    if (rst) begin
      txd_q <= 1'b1;
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
      sh_q <= {11{1'b1}};
    end else if (ce) begin
      if (start & ~busy_q) begin
        sh_q <= frame;
        busy_q <= 1'b1;
        cnt_q <= 4'h0;
      end else if (busy_q & baud) begin
        if (cnt_q == nbits) begin
          busy_q <= 1'b0;
        end else begin
          txd_q <= sh_q[0];
          sh_q <= {1'b1, sh_q[10:1]};
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end
endmodule // uwtb_tx

//--- uwtb_checker.sv
`timescale 1ns/100ps
`include "uwtb_regs.vh"
module uwtb_checker (
  input wire MCLK, // Clock
  input wire RST, // Reset
  input wire WB_CYC_I, // Cycle
  input wire WB_STB_I, // Strobe
  input wire WB_WE_I, // Write
  input wire [4:0] WB_ADR_I, // Address
  input wire [31:0] WB_DAT_I, // Write data
  input wire [31:0] WB_DAT_O, // Read data
  input wire WB_ACK_O, // Ack
  input wire TXD, // Serial out
  input wire IRQ // Interrupt
);
  wire req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  wire wr = WB_ACK_O && WB_WE_I;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  property p_ack; req |=> WB_ACK_O; endproperty
  a_ack: assert property (p_ack) else $error("request not acked");
  property p_ack_cause; WB_ACK_O |-> $past(req) ##1 !WB_ACK_O; endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
  property p_rst; $fell(RST) |-> TXD && !IRQ && !WB_ACK_O && WB_DAT_O == 32'h0; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_mask;
    wr && WB_ADR_I == `UWTB_OFS_IEN && WB_DAT_I[1:0] == 2'h0 |=> ##1 !IRQ;
  endproperty
  a_mask: assert property (p_mask) else $error("irq not masked");
  // Flags are sticky, so the line may only drop after a clear or enable write
  property p_sticky;
    $fell(IRQ) |-> $past(wr && (WB_ADR_I == `UWTB_OFS_CLR || WB_ADR_I == `UWTB_OFS_IEN), 2);
  endproperty
  a_sticky: assert property (p_sticky) else $error("irq dropped alone");
  property p_clr_rd; req && !WB_WE_I && WB_ADR_I == `UWTB_OFS_CLR |=> WB_DAT_O == 32'h0; endproperty
  a_clr_rd: assert property (p_clr_rd) else $error("clear reg readable");
  property p_sts_rd;
    req && !WB_WE_I && WB_ADR_I == `UWTB_OFS_STS && IRQ |=> WB_DAT_O[1:0] != 2'h0;
  endproperty
  a_sts_rd: assert property (p_sts_rd) else $error("irq without flag");
  property p_tx_go; wr && WB_ADR_I == `UWTB_OFS_DATA && TXD |-> ##[1:200] !TXD; endproperty
  a_tx_go: assert property (p_tx_go) else $error("write did not start tx");
  c_tx: cover property ($fell(TXD));
  c_irq: cover property ($rose(IRQ));
  c_rd: cover property (req && !WB_WE_I && WB_ADR_I == `UWTB_OFS_DATA);
endmodule // uwtb_checker
bind uwtb_top uwtb_checker i_chk (.MCLK(MCLK), .RST(RST), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .TXD(TXD), .IRQ(IRQ));

//--- uwtb_remote.sv
`timescale 1ns/100ps
module uwtb_remote #(
  parameter BIT = 8
) (
  input wire clk, // Clock
  input wire line_in, // From TXD
  input wire mode9, // Eleven-bit frames
  output reg line_out // To RXD
);
  reg [9:0] got_q; // Data, ninth, stop
  integer n_got_q = 0;
  integer i;
  initial line_out = 1'b1;
  // Mid-bit sampling tolerates up to half a bit of phase error
  always @(negedge line_in) begin
    repeat (BIT / 2) @(posedge clk);
    for (i = 0; i < (mode9 ? 10 : 9); i = i + 1) begin
      repeat (BIT) @(posedge clk);
      got_q[i] <= line_in;
    end
    n_got_q <= n_got_q + 1;
  end
  task send(input [7:0] d, input b9, input m9);
    reg [10:0] f;
    integer k;
    begin
      f = {1'b1, m9 ? b9 : 1'b1, d, 1'b0};
      for (k = 0; k < (m9 ? 11 : 10); k = k + 1) begin
        @(posedge clk);
        line_out <= f[k];
        repeat (BIT - 1) @(posedge clk);
      end
    end
  endtask
endmodule // uwtb_remote

//--- uwtb_top_bench.sv
`timescale 1ns/100ps
`include "uwtb_regs.vh"
module uwtb_top_bench;
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg ce = 1'b1;
  reg cyc = 1'b0;
  reg stb = 1'b0;
  reg we = 1'b0;
  reg [4:0] adr = 5'h00;
  reg [31:0] dat = 32'h0;
  reg [3:0] sel = 4'h0;
  reg t1 = 1'b0;
  reg osc = 1'b0;
  reg m9 = 1'b0;
  wire [31:0] rd_w;
  wire ack, rxd, txd, irq;
  reg [31:0] rdat, v;
  reg [7:0] tb, rb;
  reg md, b9, r9;
  integer n_fail = 0;
  integer checked = 0;
  integer i, k, n;
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    if ($urandom % 3 == 0)
      osc <= ~osc;
    if ($urandom % 5 == 0)
      t1 <= ~t1;
  end
  uwtb_top i_dut (.MCLK(mclk), .RST(rst), .CE(ce), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rd_w),
    .WB_ACK_O(ack), .RXD(rxd), .T1_PIN(t1), .EXT_OSC(osc), .TXD(txd), .IRQ(irq));
  uwtb_remote #(.BIT(8)) i_rem (.clk(mclk), .line_in(txd), .mode9(m9), .line_out(rxd));
  task summarize;
    begin
      if (n_fail == 0 && checked > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task check(input string what, input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task bus(input w, input [4:0] a, input [31:0] d);
    integer t;
    begin
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= 4'hF;
      t = 0;
      @(posedge mclk);
      while (ack !== 1'b1 && t < 50) begin
        @(posedge mclk);
        t = t + 1;
      end
      if (ack !== 1'b1) begin
        check("bus ack", ack, 1);
        summarize;
      end
      rdat = rd_w;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge mclk);
    end
  endtask
  task wait_sts(input [1:0] m);
    integer t;
    begin
      t = 0;
      bus(0, `UWTB_OFS_STS, 0);
      while ((rdat[1:0] & m) != m && t < 200) begin
        bus(0, `UWTB_OFS_STS, 0);
        t = t + 1;
      end
      if ((rdat[1:0] & m) != m) begin
        check("status wait", rdat, m);
        summarize;
      end
    end
  endtask
  // Eight-bit frames report the stop bit where nine-bit ones keep the ninth
  function [31:0] exp_ninth(input m, input b);
    exp_ninth = {31'h0, m ? b : 1'b1};
  endfunction
  // Auto-reload count stepped a given number of times from a start value
  function [31:0] exp_low(input [7:0] r, input [7:0] s, input integer steps);
    integer j;
    begin
      exp_low = {24'h0, s};
      for (j = 0; j < steps; j = j + 1)
        exp_low[7:0] = (exp_low[7:0] == 8'hFF) ? r : exp_low[7:0] + 8'h01;
    end
  endfunction
  initial begin
    n = $urandom(26656);
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (i = 0; i < 32; i = i + 4) begin
      bus(0, i[4:0], 0);
      check("reset value", rdat, 0);
    end
    for (i = 0; i < 8; i = i + 1) begin
      bus(1, `UWTB_OFS_TMR, {20'h0, 1'b1, i[2:0], 8'h00});
      bus(0, `UWTB_OFS_LOW, 0);
      v = rdat;
      repeat (300) @(posedge mclk);
      bus(0, `UWTB_OFS_LOW, 0);
      check("timer moves", {31'h0, rdat !== v}, {31'h0, i < 6});
    end
    bus(1, `UWTB_OFS_TMR, 32'h000008FC);
    bus(1, `UWTB_OFS_IEN, 32'h3);
    for (i = 0; i < 8; i = i + 1) begin
      md = $urandom;
      b9 = $urandom;
      r9 = $urandom;
      tb = $urandom;
      rb = $urandom;
      if (i < 2) begin
        md = i[0];
        tb = {8{i[0]}};
        rb = ~tb;
      end
      m9 <= md;
      bus(1, `UWTB_OFS_CTRL, {28'h0, b9, 1'b0, 1'b1, md});
      n = i_rem.n_got_q;
      // Random phase makes the receiver restart its own timer on the start edge
      fork
        begin
          repeat ($urandom % 16) @(posedge mclk);
          i_rem.send(rb, r9, md);
        end
        bus(1, `UWTB_OFS_DATA, {24'h0, tb});
      join
      wait_sts(2'h3);
      check("irq on", irq, 1);
      k = 0;
      while (i_rem.n_got_q == n && k < 400) begin
        @(posedge mclk);
        k = k + 1;
      end
      if (i_rem.n_got_q == n) begin
        check("frame wait", 0, 1);
        summarize;
      end
      check("frame data", i_rem.got_q[7:0], tb);
      check("frame ninth", i_rem.got_q[8], exp_ninth(md, b9));
      check("frame stop", md ? i_rem.got_q[9] : i_rem.got_q[8], 1);
      bus(0, `UWTB_OFS_DATA, 0);
      check("rx byte", rdat, {24'h0, rb});
      bus(0, `UWTB_OFS_CTRL, 0);
      check("rx ninth", rdat[`UWTB_CTRL_RXB9], exp_ninth(md, r9));
      bus(1, `UWTB_OFS_CLR, 32'h3);
      bus(0, `UWTB_OFS_STS, 0);
      check("flags cleared", {rdat[1:0], irq}, 3'h0);
    end
    m9 <= 1'b1;
    bus(1, `UWTB_OFS_CTRL, 32'h7);
    i_rem.send(8'hA5, 1'b0, 1'b1);
    repeat (8) @(posedge mclk);
    bus(0, `UWTB_OFS_STS, 0);
    check("check bit dropped", rdat, 0);
    i_rem.send(8'h5A, 1'b1, 1'b1);
    wait_sts(2'h2);
    i_rem.send(8'h33, 1'b1, 1'b1);
    repeat (8) @(posedge mclk);
    bus(0, `UWTB_OFS_DATA, 0);
    check("overrun kept", rdat, 32'h5A);
    bus(1, `UWTB_OFS_IEN, 0);
    @(posedge mclk);
    check("irq masked", irq, 0);
    bus(1, `UWTB_OFS_IEN, 32'h2);
    @(posedge mclk);
    check("irq unmasked", irq, 1);
    bus(0, `UWTB_OFS_LOW, 0);
    v = rdat;
    // Unfrozen, the count would come back to v; frozen, it stops three steps on
    ce <= 1'b0;
    repeat (21) @(posedge mclk);
    ce <= 1'b1;
    bus(0, `UWTB_OFS_LOW, 0);
    check("frozen timer", rdat, exp_low(8'hFC, v[7:0], 3));
    summarize;
  end
endmodule // uwtb_top_bench
